// File: src/ifp_core.sv
// Phase timing, fetch pipeline and branch/skip control of the core
//
// Operation
// - The system clock comes from one of four sources: fast crystal, slow crystal, fast RC, slow RC.
// - The system clock is split into four non-overlapping phase clocks.
// - The program counter advances at the end of the first phase, when the next word is fetched.
// - Decode and execute happen in the second, third and fourth phases.
// - One pass through the four phases is one instruction cycle.
// - Fetch of the next instruction overlaps execution, giving one instruction per cycle.
// - An instruction that changes the program counter takes one extra instruction cycle.
// - A branch obtains its target in its first cycle and transfers control in the second.
// - The arithmetic unit is eight bits wide and data moves through the accumulator.
// - A met skip condition discards the prefetched word and inserts a dummy cycle.
// - After reset the program counter starts at address zero.
`timescale 1ns/1ps
module ifp_core
  import ifp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic src_fast_crystal,
  input wire logic src_slow_crystal,
  input wire logic src_fast_rc,
  input wire logic src_slow_rc,
  input wire logic [1:0] clk_sel,
  input wire logic [ifp_pkg::INSTR_WIDTH-1:0] fetch_data,
  input wire logic is_branch,
  input wire logic [ifp_pkg::PC_WIDTH-1:0] branch_target,
  input wire logic skip_met,
  input wire logic [2:0] alu_op,
  input wire logic [ifp_pkg::DATA_WIDTH-1:0] alu_operand,
  output logic sys_tick,
  output logic [3:0] phase_clocks,
  output logic fetch_en,
  output logic [ifp_pkg::PC_WIDTH-1:0] fetch_addr,
  output logic [ifp_pkg::PC_WIDTH-1:0] pc,
  output logic [ifp_pkg::INSTR_WIDTH-1:0] exec_word,
  output logic exec_valid,
  output logic exec_dummy,
  output logic cycle_end,
  output logic [ifp_pkg::DATA_WIDTH-1:0] acc
);
  import ifp_pkg::*;

  logic [3:0] src_sync1_q;
  logic [3:0] src_sync2_q;
  logic src_prev_q;
  logic [3:0] src_in;
  logic src_level;
  logic [1:0] sel_q;
  ifp_phase_type phase_q;
  logic [PC_WIDTH-1:0] pc_q;
  logic [INSTR_WIDTH-1:0] ir_q;
  logic ir_valid_q;
  logic branch_pend_q;
  logic [PC_WIDTH-1:0] target_q;
  logic dummy_q;
  logic [DATA_WIDTH-1:0] acc_q;
  logic [DATA_WIDTH-1:0] alu_res;

  assign src_in = {src_slow_rc, src_fast_rc, src_slow_crystal, src_fast_crystal};

  // Selection register, sampled once per instruction cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q <= CLK_SEL_RESET;
    end else if (sys_tick && phase_q == PH_FOURTH) begin
      sel_q <= clk_sel;
    end
  end

  // All oscillators pass two flops before the select, edge gives the tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_sync1_q <= 4'h0;
      src_sync2_q <= 4'h0;
      src_prev_q <= 1'b0;
    end else begin
      src_sync1_q <= src_in;
      src_sync2_q <= src_sync1_q;
      src_prev_q <= src_level;
    end
  end
  assign src_level = src_sync2_q[sel_q];
  assign sys_tick = src_level && !src_prev_q;

  // Four-phase sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_FIRST;
    end else if (sys_tick) begin
      case (phase_q)
        PH_FIRST: phase_q <= PH_SECOND;
        PH_SECOND: phase_q <= PH_THIRD;
        PH_THIRD: phase_q <= PH_FOURTH;
        PH_FOURTH: phase_q <= PH_FIRST;
        default: phase_q <= PH_FIRST;
      endcase
    end
  end

  always_comb begin
    phase_clocks = 4'h0;
    case (phase_q)
      PH_FIRST: phase_clocks = 4'h1;
      PH_SECOND: phase_clocks = 4'h2;
      PH_THIRD: phase_clocks = 4'h4;
      PH_FOURTH: phase_clocks = 4'h8;
      default: phase_clocks = 4'h0;
    endcase
  end

  assign fetch_en = sys_tick && phase_q == PH_FIRST;
  assign fetch_addr = pc_q;
  assign cycle_end = sys_tick && phase_q == PH_FOURTH;

  // Program counter and prefetch register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= PC_RESET;
      ir_q <= NOP_WORD;
      ir_valid_q <= 1'b0;
    end else if (fetch_en) begin
      if (branch_pend_q) begin
        pc_q <= target_q;
        ir_q <= NOP_WORD;
        ir_valid_q <= 1'b0;
      end else if (dummy_q) begin
        pc_q <= pc_q + 11'h001;
        ir_q <= NOP_WORD;
        ir_valid_q <= 1'b0;
      end else begin
        pc_q <= pc_q + 11'h001;
        ir_q <= fetch_data;
        ir_valid_q <= 1'b1;
      end
    end
  end

  // Branch or skip decided in the fourth phase of an executing word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      branch_pend_q <= 1'b0;
      target_q <= PC_RESET;
      dummy_q <= 1'b0;
    end else if (cycle_end) begin
      branch_pend_q <= ir_valid_q && is_branch;
      target_q <= branch_target;
      dummy_q <= ir_valid_q && !is_branch && skip_met;
    end
  end

  // Eight-bit arithmetic unit and accumulator
  always_comb begin
    case (ifp_op_type'(alu_op))
      OP_ADD: alu_res = acc_q + alu_operand;
      OP_SUB: alu_res = acc_q - alu_operand;
      OP_AND: alu_res = acc_q & alu_operand;
      OP_OR: alu_res = acc_q | alu_operand;
      OP_XOR: alu_res = acc_q ^ alu_operand;
      OP_LOAD: alu_res = alu_operand;
      default: alu_res = acc_q;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q <= ACC_RESET;
    end else if (sys_tick && phase_q == PH_THIRD && ir_valid_q) begin
      acc_q <= alu_res;
    end
  end

  assign pc = pc_q;
  assign exec_word = ir_q;
  assign exec_valid = ir_valid_q && phase_q != PH_FIRST;
  assign exec_dummy = !ir_valid_q;
  assign acc = acc_q;

  // Assertions
  sequence fetch_s;
    fetch_en;
  endsequence
  sequence branch_s;
    cycle_end && ir_valid_q && is_branch;
  endsequence
  sequence flush_s;
    fetch_en && branch_pend_q;
  endsequence

  phase_onehot_a: assert property (@(posedge clk) disable iff (rst)
    $onehot(phase_clocks)) else $error("phase clocks not one-hot");
  phase_step_a: assert property (@(posedge clk) disable iff (rst)
    cycle_end |=> phase_clocks == 4'h1) else $error("cycle did not wrap");
  pc_incr_a: assert property (@(posedge clk) disable iff (rst)
    fetch_s ##0 !branch_pend_q |=> pc == $past(pc) + 11'h001)
    else $error("pc not advanced");
  branch_flush_a: assert property (@(posedge clk) disable iff (rst)
    flush_s |=> exec_dummy && exec_word == NOP_WORD) else $error("no flush");
  branch_load_a: assert property (@(posedge clk) disable iff (rst)
    fetch_en && branch_pend_q |=> pc == $past(target_q)) else $error("target not loaded");
  skip_dummy_a: assert property (@(posedge clk) disable iff (rst)
    fetch_en && dummy_q |=> exec_dummy && ir_q == NOP_WORD) else $error("skip kept word");
  seq_fetch_a: assert property (@(posedge clk) disable iff (rst)
    fetch_en && !branch_pend_q && !dummy_q |=> exec_word == $past(fetch_data))
    else $error("fetched word lost");
  acc_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(sys_tick && phase_q == PH_THIRD) |=> $stable(acc)) else $error("acc moved off phase");
  reset_pc_a: assert property (@(posedge clk)
    $fell(rst) |-> pc == PC_RESET) else $error("pc not zero after reset");
  branch_mark_a: assert property (@(posedge clk) disable iff (rst)
    branch_s |=> branch_pend_q && target_q == $past(branch_target))
    else $error("branch not held");
  skip_mark_a: assert property (@(posedge clk) disable iff (rst)
    cycle_end && ir_valid_q && !is_branch && skip_met |=> dummy_q)
    else $error("skip not held");
  dummy_ignore_a: assert property (@(posedge clk) disable iff (rst)
    cycle_end && !ir_valid_q |=> !branch_pend_q && !dummy_q)
    else $error("dummy cycle obeyed a request");
  fetch_phase_a: assert property (@(posedge clk) disable iff (rst)
    phase_clocks[0] |-> !exec_valid) else $error("valid in fetch phase");

  // Ticks since the last cycle end, for the cycle length check
  logic [2:0] tick_cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 3'h0;
    end else if (cycle_end) begin
      tick_cnt_q <= 3'h0;
    end else if (sys_tick) begin
      tick_cnt_q <= tick_cnt_q + 3'h1;
    end
  end
  cycle_len_a: assert property (@(posedge clk) disable iff (rst)
    cycle_end |-> tick_cnt_q == 3'(PHASE_COUNT - 1)) else $error("cycle not four phases");
endmodule : ifp_core

// File: src/ifp_pkg.sv
// Package for the instruction fetch and pipeline timing block
package ifp_pkg;
  localparam int PC_WIDTH = 11;
  localparam int INSTR_WIDTH = 16;
  localparam int DATA_WIDTH = 8;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 11'h000;
  localparam logic [DATA_WIDTH-1:0] ACC_RESET = 8'h00;
  localparam logic [INSTR_WIDTH-1:0] NOP_WORD = 16'h0000;
  localparam logic [1:0] CLK_SEL_RESET = 2'h0;
  localparam int PHASE_COUNT = 4;
  typedef enum logic [1:0] {
    SRC_FAST_CRYSTAL,
    SRC_SLOW_CRYSTAL,
    SRC_FAST_RC,
    SRC_SLOW_RC
  } ifp_src_type;
  typedef enum {
    PH_FIRST,
    PH_SECOND,
    PH_THIRD,
    PH_FOURTH
  } ifp_phase_type;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD,
    OP_SUB,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_LOAD,
    OP_PASS
  } ifp_op_type;
endpackage : ifp_pkg

// File: tb/ifp_prog_mem.sv
// Program memory model answering each fetch
`timescale 1ns/1ps
module ifp_prog_mem
  import ifp_pkg::*;
(
  input wire logic clk,
  input wire logic fetch_en,
  input wire logic [ifp_pkg::PC_WIDTH-1:0] fetch_addr,
  output logic [ifp_pkg::INSTR_WIDTH-1:0] fetch_data
);
  logic [15:0] junk_q = 16'hA5A5;
  // Word only valid in the fetch cycle, churning otherwise
  always @(posedge clk) junk_q <= ~junk_q ^ 16'h0101;
  assign fetch_data = fetch_en ? {5'h0B, fetch_addr} : junk_q;
endmodule : ifp_prog_mem

// File: tb/testbench.sv
// Self-checking bench for the fetch pipeline timing core
`timescale 1ns/1ps
module testbench;
  import ifp_pkg::*;
  logic clk = 0, rst = 1, br = 0, sk = 0, cd, nd;
  logic [3:0] osc = 0, phase_clocks;
  logic [1:0] sel = 0;
  logic [2:0] op = 0;
  logic [7:0] opd = 0, acc, ea = 0, a;
  logic [10:0] tgt = 0, fetch_addr, pc, cp, np, nt;
  logic [15:0] fdata, exec_word;
  logic [31:0] r;
  logic [22:0] e;
  logic [3:0] ph = 4'h1;
  logic [1:0] selm = 0;
  int gap = 0, stab = 0;
  logic sys_tick, fetch_en, exec_valid, exec_dummy, cycle_end;
  integer seed = 32'hab40;
  int errors = 0, num_checks = 0, cyc = 0;
  logic [22:0] fq[$];
  logic [7:0] aq[$];
  ifp_core DUT (.clk(clk), .rst(rst), .src_fast_crystal(osc[0]), .src_slow_crystal(osc[1]),
    .src_fast_rc(osc[2]), .src_slow_rc(osc[3]), .clk_sel(sel), .fetch_data(fdata),
    .is_branch(br), .branch_target(tgt), .skip_met(sk), .alu_op(op), .alu_operand(opd),
    .sys_tick(sys_tick), .phase_clocks(phase_clocks), .fetch_en(fetch_en),
    .fetch_addr(fetch_addr), .pc(pc), .exec_word(exec_word), .exec_valid(exec_valid),
    .exec_dummy(exec_dummy), .cycle_end(cycle_end), .acc(acc));
  ifp_prog_mem mem (.clk(clk), .fetch_en(fetch_en), .fetch_addr(fetch_addr),
    .fetch_data(fdata));
  always #25 clk = ~clk;
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // Oscillators at four different rates, toggling every 3, 5, 7 and 9 clocks, and the hang limit
  always @(negedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) if (cyc % (3 + 2 * i) == 0) osc[i] <= ~osc[i];
    if (cyc > 20000) begin
      errors++;
      test_done();
    end
  end
  // Watcher: pops the oldest note whenever a result appears
  always @(posedge clk) if (!rst) begin
    check("phase_onehot", 16'h1, {15'h0, $onehot(phase_clocks)});
    check("phase_clocks", {12'h0, ph}, {12'h0, phase_clocks});
    check("cycle_end", {15'h0, sys_tick & ph[3]}, {15'h0, cycle_end});
    check("fetch_en", {15'h0, sys_tick & ph[0]}, {15'h0, fetch_en});
    gap++;
    // Tick spacing must match the selected oscillator once settled
    if (sys_tick === 1'b1) begin
      if (stab > 1) check("tick_gap", 16'(6 + 4 * selm), 16'(gap));
      gap = 0;
      stab++;
      ph = {ph[2:0], ph[3]};
    end
    if (cycle_end === 1'b1) begin
      a = aq.size() ? aq.pop_front() : 8'hXX;
      check("acc", {8'h0, a}, {8'h0, acc});
      if (sel !== selm) begin
        selm = sel;
        stab = 0;
      end
    end
    if (fetch_en === 1'b1) begin
      e = fq.size() ? fq.pop_front() : 'x;
      check("fetch_addr", {5'h0, e[10:0]}, {5'h0, fetch_addr});
      check("exec_valid", 16'h0, {15'h0, exec_valid});
      #1;
      check("exec_dummy", {15'h0, e[22]}, {15'h0, exec_dummy});
      check("exec_word", e[22] ? NOP_WORD : {5'h0B, e[10:0]}, exec_word);
      check("exec_valid", {15'h0, !e[22]}, {15'h0, exec_valid});
      check("pc", {5'h0, e[21:11]}, {5'h0, pc});
    end
  end
  initial begin
    fq.push_back({1'b0, 11'h001, 11'h000});
    aq.push_back(8'h00);
    repeat (6) @(negedge clk);
    rst = 0;
    cp = 0;
    cd = 0;
    repeat (60) begin
      @(negedge clk);
      while (cycle_end !== 1'b1) @(negedge clk);
      r = $random(seed);
      br = r[0] & r[1];
      sk = r[2] & r[3];
      tgt = r[14:4];
      sel = r[17:16];
      op = r[22:20];
      opd = r[31:24];
      // Requests during a dummy cycle are ignored; branch wins
      if (cd) begin
        np = nt;
        nd = 0;
      end else if (br) begin
        np = cp + 11'h1;
        nd = 1;
        nt = tgt;
      end else if (sk) begin
        np = cp + 11'h1;
        nd = 1;
        nt = cp + 11'h2;
      end else begin
        np = cp + 11'h1;
        nd = 0;
      end
      fq.push_back({nd, nd ? nt : np + 11'h1, np});
      if (!nd) begin
        case (op)
          3'h1: ea = ea + opd;
          3'h2: ea = ea - opd;
          3'h3: ea = ea & opd;
          3'h4: ea = ea | opd;
          3'h5: ea = ea ^ opd;
          3'h6: ea = opd;
          default: ea = ea;
        endcase
      end
      aq.push_back(ea);
      cp = np;
      cd = nd;
      @(negedge clk);
      br = 0;
      sk = 0;
    end
    test_done();
  end
endmodule : testbench
